// ---- hw/aadsc_seq.sv ----
// Conversion sequencer: hold edge detect, conversion timing, channel
// select, tracking and external sample/hold control outputs.
// Assumes hold, channel select and sleep come from synchronous dividers.
`timescale 1ns/10ps

// Functional notes
// RQ1: Drive two sample/hold controls and two tracking outputs.
// RQ2: Stereo alternates left and right, half a sample period apart.
// RQ3: Second control holds right from left freeze until right conversion starts.
// RQ4: Every conversion lasts 192 master clock cycles at least.
// RQ5: External sample/hold must acquire within 192 cycles.
// RQ6: First control holds both inputs during each conversion.
// RQ7: Constant channel select converts one channel at full rate.
// RQ8: At conversion end exactly one tracking output goes low.
// RQ9: Sleep low enters low power, calibration data kept.
// RQ10: Sleep high accepts conversions at once, no recalibration.
// RQ11: On conversion end the array tracks the selected input.
// RQ12: Code high gives two's complement, low offset binary.
// RQ13: Hold falling edge starts conversion; low one cycle plus 50 ns.
// RQ14: Channel select sampled at conversion end picks next input.
// RQ15: Stereo party toggles channel select per conversion, stable 30 ns.
// RQ16: Tracking output returns high when next conversion starts.
module aadsc_seq
    import aadsc_pkg::*;
(
    input wire logic i_clock, // Master clock
    input wire logic i_nrst, // Async reset, active low
    input wire logic i_enable, // Clock enable
    input wire logic i_hold_n, // Hold and convert, falling edge
    input wire logic i_left_sel, // High selects left channel
    input wire logic i_sleep_n, // Low enters power down
    input wire logic i_code_twos, // Output coding select
    input wire logic [aadsc_pkg::DATA_W-1:0] i_raw_result, // SAR result
    output logic o_first_sample_hold_ctl, // High holds both inputs
    output logic o_second_sample_hold_ctl, // High holds right input
    output logic o_left_tracking_flag_n, // Low: left being acquired
    output logic o_right_tracking_flag_n, // Low: right being acquired
    output logic o_array_on_left, // Array tied to left input
    output logic o_tracking, // Array tracking
    output logic o_converting, // Conversion in progress
    output logic o_low_power, // Quiescent state
    output logic [aadsc_pkg::DATA_W-1:0] o_data, // Coded result
    output logic o_data_channel, // Channel of o_data
    output logic o_data_valid // Result strobe
);
    import aadsc_pkg::*;

    // =========================================================
    // State
    aadsc_state_t state;
    aadsc_state_t next_state;
    logic hold_prev;
    logic [CNT_W-1:0] count;
    logic cur_ch;
    logic hold_fall;
    logic conv_done;
    logic conv_start;
    logic pick_left;
    aadsc_res_if res ();

    // =========================================================
    // Hold edge detect and conversion events
    // Idle level of hold is high, so a low hold at the first
    // edge after reset still counts as a start
    assign hold_fall = hold_prev & ~i_hold_n; // RQ13
    assign conv_done = (state == AADSC_CONV) && (count == CONV_LAST); // RQ4

    // A fall seen with sleep low starts nothing and touches no output
    assign conv_start = (state == AADSC_IDLE) && i_sleep_n && hold_fall; // RQ13
    assign pick_left = (i_left_sel == CH_LEFT); // RQ14

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            hold_prev <= 1'b1;
        end else if (i_enable) begin
            hold_prev <= i_hold_n;
        end
    end

    // =========================================================
    // Sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            AADSC_IDLE: begin
                // Sleep outranks a start so a start never delays power down from idle
                if (!i_sleep_n) begin
                    next_state = AADSC_SLEEP; // RQ9
                end else if (hold_fall) begin
                    next_state = AADSC_CONV; // RQ13
                end
            end
            AADSC_CONV: begin
                // Sleep waits for the conversion to finish so no result is torn
                if (conv_done) begin
                    next_state = i_sleep_n ? AADSC_IDLE : AADSC_SLEEP; // RQ11
                end
            end
            AADSC_SLEEP: begin
                if (i_sleep_n) begin
                    next_state = AADSC_IDLE; // RQ10
                end
            end
            default: next_state = AADSC_IDLE;
        endcase
    end

    // =========================================================
    // State register
    // Illegal codes fall back to idle through the default arm
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= AADSC_IDLE;
        end else if (i_enable) begin
            state <= next_state;
        end
    end

    // =========================================================
    // Conversion timer
    // Counts enabled cycles only, so a frozen clock enable stretches
    // the conversion instead of shortening it
    // Runs 0 to CONV_LAST, one enabled cycle per step
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            count <= '0;
        end else if (i_enable) begin
            if (state == AADSC_CONV && !conv_done) begin
                count <= count + 8'h01; // RQ4
            end else begin
                count <= '0;
            end
        end
    end

    // =========================================================
    // Channel select
    // Channel select latched at conversion end picks the next acquisition
    // Select may move freely mid-conversion; only the end edge counts
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            cur_ch <= CH_LEFT;
        end else if (i_enable && conv_done) begin
            cur_ch <= i_left_sel; // RQ14 RQ2 RQ7
        end
    end

    // =========================================================
    // Tracking flags
    // Only the channel about to be acquired drops; both rise at the
    // next start, so the two are never low together
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_left_tracking_flag_n <= 1'b1;
        end else if (i_enable) begin
            if (conv_done) begin
                o_left_tracking_flag_n <= !pick_left; // RQ8
            end else if (conv_start) begin
                o_left_tracking_flag_n <= 1'b1; // RQ16
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_right_tracking_flag_n <= 1'b1;
        end else if (i_enable) begin
            if (conv_done) begin
                o_right_tracking_flag_n <= pick_left; // RQ8
            end else if (conv_start) begin
                o_right_tracking_flag_n <= 1'b1; // RQ16
            end
        end
    end

    // =========================================================
    // External sample/hold controls
    // Right held from the left freeze until a right conversion starts
    // In mono the control parks at one level; it toggles only in stereo
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_second_sample_hold_ctl <= 1'b0;
        end else if (i_enable && conv_start) begin
            o_second_sample_hold_ctl <= (cur_ch == CH_LEFT); // RQ3 RQ5
        end
    end

    // Registered from the next state so the pins that steer external
    // sample/hold units never glitch on a state decode
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_first_sample_hold_ctl <= 1'b0;
            o_converting <= 1'b0;
            o_tracking <= 1'b1;
            o_low_power <= 1'b0;
        end else if (i_enable) begin
            o_first_sample_hold_ctl <= (next_state == AADSC_CONV); // RQ6 RQ1 RQ5
            o_converting <= (next_state == AADSC_CONV);
            o_tracking <= (next_state == AADSC_IDLE); // RQ11
            o_low_power <= (next_state == AADSC_SLEEP); // RQ9
        end
    end

    assign o_array_on_left = (cur_ch == CH_LEFT); // RQ11

    // =========================================================
    // Result hand-off
    // The coder latches on the end edge, while cur_ch still names
    // the channel just converted
    assign res.valid = conv_done;
    assign res.channel = cur_ch;
    assign res.data = i_raw_result;

    aadsc_coder u_coder (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_enable(i_enable),
        .i_code_twos(i_code_twos),
        .res(res),
        .o_data(o_data),
        .o_data_channel(o_data_channel),
        .o_data_valid(o_data_valid)
    );
endmodule : aadsc_seq

// ---- inc/aadsc_pkg.sv ----
// Constants for the audio converter sampling control.
// Assumes a 100 MHz master clock feeding every flop of the block.
package aadsc_pkg;
    // =========================================================
    // Timing
    localparam int CONV_CYCLES = 192;
    localparam int HOLD_LOW_EXTRA_NS = 50;
    localparam int CLK_PERIOD_NS = 10;
    localparam int HOLD_MIN_CYCLES = 1 + (HOLD_LOW_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CONV_LAST = 8'(CONV_CYCLES - 1);
    // =========================================================
    // Data widths and channel codes
    localparam int DATA_W = 16;
    localparam logic CH_LEFT = 1'b1;
    localparam logic CH_RIGHT = 1'b0;
    localparam logic CODE_TWOS = 1'b1;
    localparam logic [DATA_W-1:0] SIGN_FLIP = 16'h8000;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    // =========================================================
    // Sequencer states
    typedef enum logic [2:0] {
        AADSC_IDLE = 3'b001,
        AADSC_CONV = 3'b010,
        AADSC_SLEEP = 3'b100
    } aadsc_state_t;
endpackage : aadsc_pkg

// ---- inc/aadsc_res_if.sv ----
// Result hand-off between the sequencer and the output coder.
// Assumes both ends run on the one master clock.
`timescale 1ns/10ps
interface aadsc_res_if;
    logic valid;
    logic channel;
    logic [15:0] data;
    modport src (output valid, output channel, output data);
    modport dst (input valid, input channel, input data);
endinterface : aadsc_res_if

// ---- hw/aadsc_coder.sv ----
// Output coder: converts raw offset-binary results to the selected format.
// Assumes the result strobe is one cycle wide and synchronous.
`timescale 1ns/10ps
module aadsc_coder
    import aadsc_pkg::*;
(
    input wire logic i_clock, // Master clock
    input wire logic i_nrst, // Async reset, active low
    input wire logic i_enable, // Clock enable
    input wire logic i_code_twos, // High: two's complement
    aadsc_res_if.dst res, // Raw result
    output logic [aadsc_pkg::DATA_W-1:0] o_data, // Coded result
    output logic o_data_channel, // Channel of o_data
    output logic o_data_valid // One-cycle strobe
);
    import aadsc_pkg::*;

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_data <= DATA_RST;
            o_data_channel <= CH_LEFT;
            o_data_valid <= 1'b0;
        end else if (i_enable) begin
            o_data_valid <= res.valid;
            if (res.valid) begin
                o_data_channel <= res.channel;
                // Two's complement is offset binary with the MSB inverted
                o_data <= (i_code_twos == CODE_TWOS) ? (res.data ^ SIGN_FLIP) : res.data; // RQ12
            end
        end
    end
endmodule : aadsc_coder

// ---- dv/aadsc_seq_sva.sv ----
// Port checks for the sampling sequencer.
// Assumes one master clock and active-low async reset; enable may drop.
`timescale 1ns/10ps
module aadsc_seq_sva (
    input wire logic i_clock, // Clock
    input wire logic i_nrst, // Reset
    input wire logic i_enable, // Enable
    input wire logic i_hold_n, // Hold
    input wire logic i_left_sel, // Select
    input wire logic i_sleep_n, // Sleep
    input wire logic o_first_sample_hold_ctl, // Ctl 1
    input wire logic o_second_sample_hold_ctl, // Ctl 2
    input wire logic o_left_tracking_flag_n, // Left flag
    input wire logic o_right_tracking_flag_n, // Right flag
    input wire logic o_array_on_left, // Array side
    input wire logic o_tracking, // Tracking
    input wire logic o_converting, // Busy
    input wire logic o_low_power, // Sleeping
    input wire logic o_data_channel, // Result side
    input wire logic o_data_valid // Strobe
);
    logic [8:0] hi_cnt;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) hi_cnt <= 9'h000;
        // Only enabled edges advance a conversion
        else hi_cnt <= o_first_sample_hold_ctl ? hi_cnt + {8'h00, i_enable} : 9'h000;
    end
    a_ctl1_width: assert property ($fell(o_first_sample_hold_ctl) |-> hi_cnt == 9'h0c0)
        else $error("hold control width wrong");
    a_ctl1_busy: assert property (o_first_sample_hold_ctl |-> o_converting && !o_tracking)
        else $error("hold control outside conversion");
    a_start_fall: assert property ($fell(i_hold_n) && o_tracking && i_sleep_n && i_enable
        |=> o_first_sample_hold_ctl) else $error("hold fall not taken");
    a_flags_start: assert property ($rose(o_first_sample_hold_ctl)
        |-> o_left_tracking_flag_n && o_right_tracking_flag_n) else $error("flag left low");
    a_one_low: assert property (o_left_tracking_flag_n || o_right_tracking_flag_n)
        else $error("both flags low");
    a_flags_end: assert property ($fell(o_first_sample_hold_ctl) |->
        o_left_tracking_flag_n == !$past(i_left_sel) && o_right_tracking_flag_n == $past(i_left_sel))
        else $error("wrong flag at end");
    a_array_end: assert property ($fell(o_first_sample_hold_ctl) |->
        o_tracking && o_array_on_left == $past(i_left_sel)) else $error("array side wrong");
    a_ctl2_start: assert property ($rose(o_first_sample_hold_ctl)
        |-> o_second_sample_hold_ctl == o_array_on_left) else $error("second control wrong");
    a_result_once: assert property ($fell(o_first_sample_hold_ctl) |-> o_data_valid &&
        o_data_channel == $past(o_array_on_left) ##1 !o_data_valid) else $error("bad strobe");
    a_sleep_in: assert property (!i_sleep_n && o_tracking && i_enable |=> o_low_power)
        else $error("sleep not entered");
    a_wake_up: assert property (o_low_power && i_sleep_n && i_enable |=> o_tracking)
        else $error("wake not immediate");
endmodule : aadsc_seq_sva
bind aadsc_seq aadsc_seq_sva chk_u (.*);

// ---- dv/aadsc_divider.sv ----
// Clock divider feeding hold and channel select, as on the board.
// Assumes the bench master clock; outputs move on falling edges.
`timescale 1ns/10ps
module aadsc_divider (
    input wire logic i_clock, // Master clock
    input wire logic i_run, // Pulse hold
    input wire logic i_stereo, // Toggle select
    input wire logic i_left, // Fixed select
    output logic o_hold_n, // Hold, active low
    output logic o_left_sel // Channel select
);
    int cnt = 0;
    initial o_hold_n = 1'b1;
    initial o_left_sel = 1'b1;
    // Period above a conversion, so each fall meets an idle sequencer
    always @(negedge i_clock) begin
        cnt <= (!i_run || cnt == 199) ? 0 : cnt + 1;
        o_hold_n <= !(i_run && cnt < 8);
        if (i_run && cnt == 8) begin
            o_left_sel <= i_stereo ? !o_left_sel : i_left;
        end
    end
endmodule : aadsc_divider

// ---- dv/aadsc_seq_tb.sv ----
// Self-checking bench for the sampling sequencer.
// Assumes the divider model drives hold and select.
`timescale 1ns/10ps
module aadsc_seq_tb;
    import aadsc_pkg::*;
    logic i_clock = 0, i_nrst = 0, i_enable = 1, i_sleep_n = 1, i_code_twos = 0;
    logic run = 0, stereo = 1, mono_left = 1, i_hold_n, i_left_sel;
    logic [DATA_W-1:0] i_raw_result = 16'h1234, o_data;
    logic o_first_sample_hold_ctl, o_second_sample_hold_ctl, o_left_tracking_flag_n;
    logic o_right_tracking_flag_n, o_array_on_left, o_tracking, o_converting;
    logic o_low_power, o_data_channel, o_data_valid;
    int n_mismatch = 0, samples_checked = 0, cycles = 0;
    always #5 i_clock = ~i_clock;
    aadsc_seq dut_u (.*);
    aadsc_divider div_u (.i_clock, .i_run(run), .i_stereo(stereo), .i_left(mono_left),
        .o_hold_n(i_hold_n), .o_left_sel(i_left_sel));
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic wait_valid();
        int k;
        k = 0;
        @(negedge i_clock);
        while (o_data_valid !== 1'b1 && k < 450) begin
            @(negedge i_clock);
            k++;
        end
        chk("valid", 16'h0001, {15'h0000, o_data_valid});
    endtask : wait_valid
    task automatic check_result(input logic ch);
        chk("chan", {15'h0000, ch}, {15'h0000, o_data_channel});
        chk("data", i_code_twos ? i_raw_result ^ SIGN_FLIP : i_raw_result, o_data);
        chk("left_tracking_flag", {15'h0000, !i_left_sel}, {15'h0000, o_left_tracking_flag_n});
        chk("right_tracking_flag", {15'h0000, i_left_sel}, {15'h0000, o_right_tracking_flag_n});
        i_raw_result = i_raw_result + 16'h4321;
    endtask : check_result
    task automatic t_stereo();
        logic exp_ch;
        exp_ch = 1'b1;
        run = 1;
        repeat (4) begin
            wait_valid();
            check_result(exp_ch);
            exp_ch = i_left_sel;
        end
    endtask : t_stereo
    task automatic t_freeze();
        int n;
        n = 0;
        while (o_first_sample_hold_ctl !== 1'b1 && n < 450) begin
            @(negedge i_clock);
            n++;
        end
        n = 0;
        // Enable dropped for five edges in mid-conversion
        while (o_first_sample_hold_ctl === 1'b1 && n < 450) begin
            i_enable = (n < 20 || n >= 25) ? 1'b1 : 1'b0;
            @(negedge i_clock);
            n++;
        end
        i_enable = 1'b1;
        chk("width", 16'(CONV_CYCLES + 5), 16'(n));
        chk("fvalid", 16'h0001, {15'h0000, o_data_valid});
    endtask : t_freeze
    task automatic t_mono(input logic side);
        stereo = 0;
        mono_left = side;
        i_code_twos = 1;
        wait_valid();
        repeat (3) begin
            wait_valid();
            check_result(side);
        end
    endtask : t_mono
    task automatic t_sleep();
        i_sleep_n = 0;
        repeat (450) @(negedge i_clock);
        chk("lowpow", 16'h0001, {15'h0000, o_low_power});
        chk("ctl1", 16'h0000, {15'h0000, o_first_sample_hold_ctl});
        i_sleep_n = 1;
        wait_valid();
        chk("awake", 16'h0000, {15'h0000, o_low_power});
    endtask : t_sleep
    task automatic close_out();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out
    always @(posedge i_clock) begin
        cycles++;
        if (cycles > 6000) begin
            n_mismatch++;
            close_out();
        end
    end
    initial begin
        repeat (3) @(negedge i_clock);
        i_nrst = 1;
        t_stereo();
        t_freeze();
        t_mono(1'b1);
        t_mono(1'b0);
        t_sleep();
        close_out();
    end
endmodule : aadsc_seq_tb
